// ### common/iso_tx_irq_pkg.sv
// Purpose : Shared constants and types for the transmitter event status block
// Assumes : 32-bit AXI4-Lite register access, one clock domain
// Notes   : Offsets are byte addresses
package iso_tx_irq_pkg;

  // ==========================================================================
  // Register map
  localparam logic [11:0] TX_EVENT_STATUS_OFS = 12'h02C;
  localparam logic [11:0] TX_EVENT_ENABLE_OFS = 12'h030;
  localparam int          ADDR_W              = 12;
  localparam int          DATA_W              = 32;

  // ==========================================================================
  // Field layout and reset values
  localparam int          STATUS_W            = 10;
  localparam int          ENABLE_W            = 14;
  localparam logic [9:0]  STATUS_RESET        = 10'h000;
  localparam logic [13:0] ENABLE_RESET        = 14'h0000;
  localparam int          BIT_EMPTY           = 0;
  localparam int          BIT_FULL            = 1;
  localparam int          BIT_LOST_CYCLE      = 2;
  localparam int          BIT_INPUT_ERR       = 3;
  localparam int          BIT_DBC_LOSS        = 4;
  localparam int          BIT_PAYLOAD_DONE    = 5;
  localparam int          BIT_STAMP_SENT      = 6;
  localparam int          BIT_NEAR_LARGE      = 7;
  localparam int          BIT_NEAR_MID        = 8;
  localparam int          BIT_NEAR_SMALL      = 9;

  // ==========================================================================
  // Queue fill thresholds, in quadlets short of full
  localparam int          FREE_W              = 12;
  localparam logic [11:0] THRESH_SMALL        = 12'd100;
  localparam logic [11:0] THRESH_MID          = 12'd256;
  localparam logic [11:0] THRESH_LARGE        = 12'd512;

  // ==========================================================================
  // Bus answers
  localparam logic [1:0]  RESP_OKAY           = 2'h0;
  localparam logic [1:0]  RESP_SLVERR         = 2'h2;

  // Register selector from address decode
  typedef enum logic [2:0] {
    SEL_NONE   = 3'b001,
    SEL_STATUS = 3'b010,
    SEL_ENABLE = 3'b100
  } reg_sel_t;

  // Transmitter event inputs, one clock wide or level as noted
  typedef struct packed {
    logic [FREE_W-1:0] queue_free;             // Level, free quadlets in queue
    logic              half_k_buffer;          // Level, 0.5K buffer size selected
    logic              stamp_sent_event;       // Pulse
    logic              payload_done_event;     // Pulse
    logic              block_count_sync_loss;  // Pulse
    logic              input_error_event;      // Pulse
    logic              cycle_lost_event;       // Pulse
    logic              tx_memory_full;         // Level, memory bank full
    logic              tx_memory_empty;        // Level, memory bank empty
  } tx_events_t;

endpackage

// ### logic/queue_level_detect.sv
// Purpose : Flags the moment free queue space falls to a threshold
// Assumes : free count from logic on the same clock
// Notes   : One pulse per downward crossing
`timescale 1ns/10ps
module queue_level_detect
  import iso_tx_irq_pkg::*;
#(
  parameter logic [FREE_W-1:0] THRESH = 12'h064
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic [FREE_W-1:0] queue_free,
  input  wire logic              allow,
  output logic                   hit
);

  logic below_reg;
  logic below_next;

  // ==========================================================================
  // Crossing detect, level remembered so a held level fires once
  always_comb begin
    below_next = (queue_free <= THRESH);
    hit        = below_next & ~below_reg & allow;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      below_reg <= 1'b0;
    end else begin
      below_reg <= below_next;
    end
  end

endmodule

// ### logic/iso_tx_interrupt_status_enable.sv
// Purpose : Transmitter event status, enable and interrupt logic
// Assumes : Event inputs come from logic on ref_clk
// Notes   : Registers reached over AXI4-Lite, status bits write-one-to-clear
//
// Operation
// - Set status bit 9 when queue free space falls to 100 quadlets.
// - Set status bit 8 when queue free space falls to 256 quadlets.
// - Set status bit 7 at 512 quadlets free, never with the 0.5K buffer size.
// - Set status bit 6 when a time stamp goes out in header quadlet two.
// - Set status bit 5 when a payload finishes sending or being discarded.
// - Set status bit 4 when the data block counter loses sync.
// - Set status bit 3 on an input error that drops application data.
// - Set status bit 2 when a bus cycle is lost and its payload dropped.
// - Faults of bits 2, 3 and 4 are recovered by the device without the host.
// - Memory full sets status bit 1 and resets the transmitter on its own.
// - Set status bit 0 when the transmit memory bank becomes empty.
// - Status bits above 9 always read as zero.
// - Enable bits 9 down to 0 gate the matching status bits; enable bits 13 to 10 gate nothing.
`timescale 1ns/10ps
module iso_tx_interrupt_status_enable
  import iso_tx_irq_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire tx_events_t        events,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Block outputs
  output logic                   tx_irq,
  output logic                   tx_auto_reset,
  output logic                   tx_recover_req
);

  // ==========================================================================
  // Functions
  // Address decode, shared by read and write paths
  function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    return (addr == TX_EVENT_STATUS_OFS) ? SEL_STATUS :
           (addr == TX_EVENT_ENABLE_OFS) ? SEL_ENABLE : SEL_NONE;
  endfunction

  // Byte lane merge of write data into an old word
  function automatic logic [DATA_W-1:0] merge_strb(input logic [DATA_W-1:0] old_w,
                                                   input logic [DATA_W-1:0] new_w,
                                                   input logic [3:0]        strb);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // Declarations
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rd_state_t;
  wr_state_t             wr_state_reg,   wr_state_next;
  rd_state_t             rd_state_reg,   rd_state_next;
  logic                  aw_got_reg,     aw_got_next;
  logic                  w_got_reg,      w_got_next;
  logic [ADDR_W-1:0]     awaddr_reg,     awaddr_next;
  logic [DATA_W-1:0]     wdata_reg,      wdata_next;
  logic [3:0]            wstrb_reg,      wstrb_next;
  logic                  awready_reg,    awready_next;
  logic                  wready_reg,     wready_next;
  logic                  bvalid_reg,     bvalid_next;
  logic [1:0]            bresp_reg,      bresp_next;
  logic                  arready_reg,    arready_next;
  logic                  rvalid_reg,     rvalid_next;
  logic [1:0]            rresp_reg,      rresp_next;
  logic [DATA_W-1:0]     rdata_reg,      rdata_next;
  logic [STATUS_W-1:0]   status_reg,     status_next;
  logic [ENABLE_W-1:0]   enable_reg,     enable_next;
  logic                  irq_reg,        irq_next;
  logic                  auto_rst_reg,   auto_rst_next;
  logic                  recover_reg,    recover_next;
  logic                  full_seen_reg,  full_seen_next;
  logic                  empty_seen_reg, empty_seen_next;
  logic [2:0]            near_hit;
  logic [STATUS_W-1:0]   set_bits;
  logic [STATUS_W-1:0]   clr_bits;
  logic                  do_write;
  reg_sel_t              wr_sel;
  reg_sel_t              rd_sel;
  logic [DATA_W-1:0]     wr_word;
  // Threshold table for the three fill detectors
  localparam logic [3*FREE_W-1:0] THRESH_TABLE = {THRESH_LARGE, THRESH_MID, THRESH_SMALL};

  // ==========================================================================
  // Queue fill detectors, one per threshold
  generate
    for (genvar g = 0; g < 3; g++) begin : g_near
      queue_level_detect #(
        .THRESH     (THRESH_TABLE[g*FREE_W +: FREE_W])
      ) u_detect (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .queue_free (events.queue_free),
        // Large threshold is meaningless with the small buffer
        .allow      ((g == 2) ? ~events.half_k_buffer : 1'b1),
        .hit        (near_hit[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Event collection
  always_comb begin
    set_bits                   = '0;
    set_bits[BIT_NEAR_SMALL]   = near_hit[0];
    set_bits[BIT_NEAR_MID]     = near_hit[1];
    set_bits[BIT_NEAR_LARGE]   = near_hit[2];
    set_bits[BIT_STAMP_SENT]   = events.stamp_sent_event;
    set_bits[BIT_PAYLOAD_DONE] = events.payload_done_event;
    set_bits[BIT_DBC_LOSS]     = events.block_count_sync_loss;
    set_bits[BIT_INPUT_ERR]    = events.input_error_event;
    set_bits[BIT_LOST_CYCLE]   = events.cycle_lost_event;
    set_bits[BIT_FULL]         = events.tx_memory_full & ~full_seen_reg;
    set_bits[BIT_EMPTY]        = events.tx_memory_empty & ~empty_seen_reg;
    full_seen_next             = events.tx_memory_full;
    empty_seen_next            = events.tx_memory_empty;
    // Full is fatal, the transmitter restarts without waiting on software
    auto_rst_next              = set_bits[BIT_FULL];
    // Self-repairing faults kick the datapath recovery directly
    recover_next               = set_bits[BIT_LOST_CYCLE] | set_bits[BIT_INPUT_ERR]
                               | set_bits[BIT_DBC_LOSS];
  end

  // ==========================================================================
  // Write channel
  always_comb begin
    wr_state_next = wr_state_reg;
    aw_got_next   = aw_got_reg;
    w_got_next    = w_got_reg;
    awaddr_next   = awaddr_reg;
    wdata_next    = wdata_reg;
    wstrb_next    = wstrb_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    do_write      = 1'b0;
    wr_sel        = decode_addr(awaddr_reg);
    if (s_axi_awvalid && awready_reg) begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    case (wr_state_reg)
      WR_IDLE: begin
        // Address and data may arrive in either order
        if (aw_got_reg && w_got_reg) begin
          do_write      = (wr_sel != SEL_NONE);
          bresp_next    = (wr_sel != SEL_NONE) ? RESP_OKAY : RESP_SLVERR;
          bvalid_next   = 1'b1;
          aw_got_next   = 1'b0;
          w_got_next    = 1'b0;
          wr_state_next = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_next   = 1'b0;
          wr_state_next = WR_IDLE;
        end
      end
      default: begin
        wr_state_next = WR_IDLE;
        bvalid_next   = 1'b0;
      end
    endcase
    // Readies registered; low while a word is held or a response is owed
    awready_next = (wr_state_next == WR_IDLE) && !aw_got_next && !do_write;
    wready_next  = (wr_state_next == WR_IDLE) && !w_got_next && !do_write;
  end

  // ==========================================================================
  // Status and enable registers
  always_comb begin
    status_next = status_reg;
    enable_next = enable_reg;
    clr_bits    = '0;
    wr_word     = '0;
    if (do_write && wr_sel == SEL_STATUS) begin
      // Unwritten lanes clear nothing
      wr_word  = merge_strb('0, wdata_reg, wstrb_reg);
      clr_bits = wr_word[STATUS_W-1:0];
    end
    if (do_write && wr_sel == SEL_ENABLE) begin
      wr_word     = merge_strb({{(DATA_W-ENABLE_W){1'b0}}, enable_reg}, wdata_reg, wstrb_reg);
      enable_next = wr_word[ENABLE_W-1:0];
    end
    // Sticky bits; an event in the clearing cycle survives the clear
    status_next = (status_reg & ~clr_bits) | set_bits;
    // Registered so the pin has no glitch from the clear path
    irq_next    = |(status_next & enable_next[STATUS_W-1:0]);
  end

  // ==========================================================================
  // Read channel
  always_comb begin
    rd_state_next = rd_state_reg;
    rvalid_next   = rvalid_reg;
    rresp_next    = rresp_reg;
    rdata_next    = rdata_reg;
    rd_sel        = decode_addr(s_axi_araddr);
    case (rd_state_reg)
      RD_IDLE: begin
        if (s_axi_arvalid && arready_reg) begin
          rvalid_next   = 1'b1;
          rresp_next    = RESP_OKAY;
          rd_state_next = RD_RESP;
          case (rd_sel)
            // Bits above the event field read zero
            SEL_STATUS: rdata_next = {{(DATA_W-STATUS_W){1'b0}}, status_reg};
            SEL_ENABLE: rdata_next = {{(DATA_W-ENABLE_W){1'b0}}, enable_reg};
            default: begin
              rdata_next = '0;
              rresp_next = RESP_SLVERR;
            end
          endcase
        end
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          rvalid_next   = 1'b0;
          rd_state_next = RD_IDLE;
        end
      end
      default: begin
        rd_state_next = RD_IDLE;
        rvalid_next   = 1'b0;
      end
    endcase
    arready_next = (rd_state_next == RD_IDLE);
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_state_reg   <= WR_IDLE;
      rd_state_reg   <= RD_IDLE;
      aw_got_reg     <= 1'b0;
      w_got_reg      <= 1'b0;
      awaddr_reg     <= '0;
      wdata_reg      <= '0;
      wstrb_reg      <= '0;
      awready_reg    <= 1'b0;
      wready_reg     <= 1'b0;
      bvalid_reg     <= 1'b0;
      bresp_reg      <= RESP_OKAY;
      arready_reg    <= 1'b0;
      rvalid_reg     <= 1'b0;
      rresp_reg      <= RESP_OKAY;
      rdata_reg      <= '0;
      status_reg     <= STATUS_RESET;
      enable_reg     <= ENABLE_RESET;
      irq_reg        <= 1'b0;
      auto_rst_reg   <= 1'b0;
      recover_reg    <= 1'b0;
      full_seen_reg  <= 1'b0;
      empty_seen_reg <= 1'b0;
    end else begin
      wr_state_reg   <= wr_state_next;
      rd_state_reg   <= rd_state_next;
      aw_got_reg     <= aw_got_next;
      w_got_reg      <= w_got_next;
      awaddr_reg     <= awaddr_next;
      wdata_reg      <= wdata_next;
      wstrb_reg      <= wstrb_next;
      awready_reg    <= awready_next;
      wready_reg     <= wready_next;
      bvalid_reg     <= bvalid_next;
      bresp_reg      <= bresp_next;
      arready_reg    <= arready_next;
      rvalid_reg     <= rvalid_next;
      rresp_reg      <= rresp_next;
      rdata_reg      <= rdata_next;
      status_reg     <= status_next;
      enable_reg     <= enable_next;
      irq_reg        <= irq_next;
      auto_rst_reg   <= auto_rst_next;
      recover_reg    <= recover_next;
      full_seen_reg  <= full_seen_next;
      empty_seen_reg <= empty_seen_next;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flip-flops
  assign s_axi_awready  = awready_reg;
  assign s_axi_wready   = wready_reg;
  assign s_axi_bvalid   = bvalid_reg;
  assign s_axi_bresp    = bresp_reg;
  assign s_axi_arready  = arready_reg;
  assign s_axi_rvalid   = rvalid_reg;
  assign s_axi_rresp    = rresp_reg;
  assign s_axi_rdata    = rdata_reg;
  assign tx_irq         = irq_reg;
  assign tx_auto_reset  = auto_rst_reg;
  assign tx_recover_req = recover_reg;

endmodule

// ### bench/iso_tx_irq_chk.sv
// Purpose : Port-level checks for the transmitter event status block
// Assumes : One clock domain, bench holds events low during reset
// Notes   : Bound to the design top; pulse figures follow the hand-over timing
`timescale 1ns/10ps
module iso_tx_irq_chk
  import iso_tx_irq_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              resetn,
  input wire tx_events_t        events,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              tx_irq,
  input wire logic              tx_auto_reset,
  input wire logic              tx_recover_req
);
  // ==========================================================================
  // Helpers
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic rec_ev;
  logic rd_take;
  // Any self-repairing fault, and a taken read
  assign rec_ev  = events.cycle_lost_event | events.input_error_event
                 | events.block_count_sync_loss;
  assign rd_take = s_axi_arvalid & s_axi_arready;

  // ==========================================================================
  // Assertions
  a_full_autoreset: assert property ($rose(events.tx_memory_full) |-> ##1 tx_auto_reset)
    else $error("memory full gave no transmitter reset pulse");
  a_autoreset_single: assert property (tx_auto_reset |=> !tx_auto_reset)
    else $error("transmitter reset pulse longer than one cycle");
  a_recover_req: assert property (rec_ev |-> ##1 tx_recover_req)
    else $error("fault gave no recovery pulse");
  a_recover_cause: assert property (tx_recover_req |-> $past(rec_ev, 1))
    else $error("recovery pulse without a fault");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
                                   && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data late");
  a_unmapped_read: assert property (rd_take && s_axi_araddr != TX_EVENT_STATUS_OFS
      && s_axi_araddr != TX_EVENT_ENABLE_OFS |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_status_upper: assert property (rd_take && s_axi_araddr == TX_EVENT_STATUS_OFS
      |=> s_axi_rdata[31:10] == 22'h0)
    else $error("status reads nonzero above bit 9");
  a_enable_upper: assert property (rd_take && s_axi_araddr == TX_EVENT_ENABLE_OFS
      |=> s_axi_rdata[31:14] == 18'h0)
    else $error("enable reads nonzero above bit 13");

  // Main scenarios reached
  c_irq: cover property ($rose(tx_irq));
  c_autoreset: cover property (tx_auto_reset);
  c_recover: cover property (tx_recover_req);
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

bind iso_tx_interrupt_status_enable iso_tx_irq_chk iso_tx_irq_chk_i (
  .ref_clk(ref_clk), .resetn(resetn), .events(events),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .tx_irq(tx_irq), .tx_auto_reset(tx_auto_reset), .tx_recover_req(tx_recover_req));

// ### bench/iso_tx_interrupt_status_enable_bench.sv
// Purpose : Self-checking bench for the transmitter event status block
// Assumes : Bench acts as AXI4-Lite master and event source
// Notes   : Event bits 6..0 of the struct line up with status bits 6..0
`timescale 1ns/10ps
module iso_tx_interrupt_status_enable_bench
  import iso_tx_irq_pkg::*;
;
  // ==========================================================================
  // Signals
  logic              ref_clk = 1'b0;
  logic              resetn  = 1'b0;
  tx_events_t        ev;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, data;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, tx_irq, tx_auto_reset, tx_recover_req;
  int num_errors = 0;
  int total_checks = 0;
  int rec_cnt, rst_cnt;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  iso_tx_interrupt_status_enable iso_tx_interrupt_status_enable_i (
    .ref_clk(ref_clk), .resetn(resetn), .events(ev),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_irq(tx_irq), .tx_auto_reset(tx_auto_reset), .tx_recover_req(tx_recover_req));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write: both channels offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    chk({31'h0, bvalid}, 32'h1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // Read: values sampled at the edge that sees rvalid
  task automatic rd(input logic [11:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    chk({31'h0, rvalid}, 32'h1);
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    chk(data, exp);
  endtask

  // One-cycle high on an event line, then count side pulses
  task automatic fire(input int i);
    ev[i] <= 1'b1;
    @(posedge ref_clk);
    ev[i] <= 1'b0;
    rec_cnt = 0;
    rst_cnt = 0;
    repeat (4) begin
      @(posedge ref_clk);
      rec_cnt += int'(tx_recover_req);
      rst_cnt += int'(tx_auto_reset);
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rd_chk(TX_EVENT_STATUS_OFS, 32'h0);
    rd_chk(TX_EVENT_ENABLE_OFS, 32'h0);
    chk({31'h0, tx_irq}, 32'h0);
  endtask

  // Unmapped places refused, mapped neighbour left alone
  task automatic t_bus_err;
    wr(12'h034, 32'hFFFFFFFF, 4'hF);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    rd(12'h02D);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    chk(data, 32'h0);
    rd_chk(TX_EVENT_ENABLE_OFS, 32'h0);
  endtask

  // Event bits 0 to 6: set, raise interrupt, side pulse, clear
  task automatic t_events;
    wr(TX_EVENT_ENABLE_OFS, 32'h3FFF, 4'hF);
    for (int i = 0; i < 7; i++) begin
      fire(i);
      rd_chk(TX_EVENT_STATUS_OFS, 32'h1 << i);
      chk({31'h0, tx_irq}, 32'h1);
      chk(32'(rec_cnt), (i >= 2 && i <= 4) ? 32'h1 : 32'h0);
      chk(32'(rst_cnt), (i == 1) ? 32'h1 : 32'h0);
      wr(TX_EVENT_STATUS_OFS, 32'h1 << i, 4'hF);
      rd_chk(TX_EVENT_STATUS_OFS, 32'h0);
      chk({31'h0, tx_irq}, 32'h0);
    end
  endtask

  // Free space one above, then at each threshold
  task automatic t_thresh;
    logic [11:0] th [3];
    logic [31:0] acc;
    th  = '{12'd512, 12'd256, 12'd100};
    acc = 32'h0;
    for (int k = 0; k < 3; k++) begin
      ev.queue_free <= th[k] + 12'd1;
      repeat (2) @(posedge ref_clk);
      rd_chk(TX_EVENT_STATUS_OFS, acc);
      ev.queue_free <= th[k];
      repeat (2) @(posedge ref_clk);
      acc = acc | (32'h80 << k);
      rd_chk(TX_EVENT_STATUS_OFS, acc);
    end
    wr(TX_EVENT_STATUS_OFS, 32'h380, 4'hF);
    ev.queue_free    <= 12'hFFF;
    ev.half_k_buffer <= 1'b1;
    repeat (2) @(posedge ref_clk);
    ev.queue_free <= 12'd512;
    repeat (2) @(posedge ref_clk);
    rd_chk(TX_EVENT_STATUS_OFS, 32'h0);
    ev.half_k_buffer <= 1'b0;
    ev.queue_free    <= 12'hFFF;
  endtask

  // Masking, byte lanes and read-only zeros
  task automatic t_mask;
    wr(TX_EVENT_ENABLE_OFS, 32'h0, 4'hF);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    fire(6);
    chk({31'h0, tx_irq}, 32'h0);
    rd_chk(TX_EVENT_STATUS_OFS, 32'h40);
    wr(TX_EVENT_ENABLE_OFS, 32'hFFFFFFFF, 4'hF);
    rd_chk(TX_EVENT_ENABLE_OFS, 32'h3FFF);
    chk({31'h0, tx_irq}, 32'h1);
    wr(TX_EVENT_ENABLE_OFS, 32'h0, 4'h1);
    rd_chk(TX_EVENT_ENABLE_OFS, 32'h3F00);
    chk({31'h0, tx_irq}, 32'h0);
    wr(TX_EVENT_STATUS_OFS, 32'hFFFFFFFF, 4'hF);
    rd_chk(TX_EVENT_STATUS_OFS, 32'h0);
  endtask

  // ==========================================================================
  // Run control
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Free space starts far from every threshold
  initial begin
    ev = '0;
    ev.queue_free = 12'hFFF;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_reset;
    t_bus_err;
    t_events;
    t_thresh;
    t_mask;
    finish_test;
  end

  // Run needs well under a thousand cycles
  initial begin
    #200000;
    num_errors++;
    finish_test;
  end
endmodule
